// ===== src/vector_place_pkg.sv
// constants for reset and interrupt vector placement
package vector_place_pkg;

   // ****************************************
   // vector table geometry
   // ****************************************
   localparam int          ADDR_W            = 14;          // program word address width
   localparam int          NUM_IRQ           = 25;          // interrupt sources, vectors 2..26
   localparam int          NUM_VECTORS       = 26;          // reset plus interrupts
   localparam int          IRQ_IDX_W         = 5;
   localparam logic [13:0] RESET_ADDR        = 14'h0000;    // vector 1
   localparam logic [13:0] VECTOR_STRIDE     = 14'h0002;    // two words per vector
   localparam logic [13:0] TABLE_BASE_APP    = 14'h0002;    // first interrupt vector, application
   localparam logic [13:0] LAST_VECTOR_ADDR  = 14'h0032;    // store program ready
   localparam logic [13:0] BOOT_RESET_DEFAULT = 14'h3800;   // plain default boot start

   // ****************************************
   // source indices (index 0 is vector 2)
   // ****************************************
   localparam int IDX_EXTERNAL_REQUEST_ZERO   = 0;
   localparam int IDX_EXTERNAL_REQUEST_ONE    = 1;
   localparam int IDX_PIN_CHANGE_GROUP_ZERO   = 2;
   localparam int IDX_PIN_CHANGE_GROUP_ONE    = 3;
   localparam int IDX_PIN_CHANGE_GROUP_TWO    = 4;
   localparam int IDX_WATCHDOG_TIMEOUT        = 5;
   localparam int IDX_TIMER2_COMPARE_A        = 6;
   localparam int IDX_TIMER1_CAPTURE          = 9;
   localparam int IDX_TIMER0_COMPARE_A        = 13;
   localparam int IDX_SERIAL_TRANSFER_COMPLETE = 16;
   localparam int IDX_SERIAL_TX_DATA_EMPTY    = 18;
   localparam int IDX_CONVERTER_COMPLETE      = 20;
   localparam int IDX_EEPROM_READY            = 21;
   localparam int IDX_TWO_WIRE_SERIAL         = 23;
   localparam int IDX_STORE_PROGRAM_READY     = 24;

   // ****************************************
   // core control register fields and timing
   // ****************************************
   localparam int         VECTOR_SELECT_BIT        = 1;
   localparam int         VECTOR_CHANGE_ENABLE_BIT = 0;
   localparam logic       VECTOR_SELECT_RESET      = 1'b0;
   localparam logic       FUSE_UNPROGRAMMED        = 1'b1;
   localparam int         CHANGE_WINDOW_CYCLES     = 4;
   localparam logic [2:0] CHANGE_WINDOW_COUNT      = 3'(CHANGE_WINDOW_CYCLES);

endpackage

// ===== src/interrupt_vector_placement.sv
// reset and interrupt vector address generation with vector table relocation
`timescale 1ns/1ns
module interrupt_vector_placement
   import vector_place_pkg::*;
#(
   parameter logic [13:0] BOOT_RESET_ADDR = BOOT_RESET_DEFAULT
) (
   input  wire logic                 i_clock,
   input  wire logic                 i_nrst,
   input  wire logic                 i_boot_reset_fuse,
   input  wire logic                 i_ctrl_write,
   input  wire logic [7:0]           i_ctrl_wdata,
   input  wire logic                 i_instr_done,
   input  wire logic [NUM_IRQ-1:0]   i_irq_pending,
   input  wire logic                 i_global_enable,
   input  wire logic                 i_irq_ack,
   output logic      [ADDR_W-1:0]    o_reset_addr,
   output logic      [ADDR_W-1:0]    o_table_start,
   output logic                      o_irq_request,
   output logic      [ADDR_W-1:0]    o_irq_vector_addr,
   output logic      [IRQ_IDX_W-1:0] o_irq_index,
   output logic                      o_vector_select,
   output logic                      o_vector_change_enable,
   output logic                      o_irq_blocked
);

   // ****************************************
   // source map, offsets relative to the table start
   // ****************************************
   // index  vector  offset  source
   // the offset below is what the table start is added to
   //  0      2      0x0000  external request zero
   //  1      3      0x0002  external request one
   //  2      4      0x0004  pin change group zero
   //  3      5      0x0006  pin change group one
   //  4      6      0x0008  pin change group two
   //  5      7      0x000A  watchdog timeout
   //  6      8      0x000C  timer2 compare a
   //  7      9      0x000E  timer2 compare b
   //  8     10      0x0010  timer2 overflow
   //  9     11      0x0012  timer1 capture
   // 10     12      0x0014  timer1 compare a
   // 11     13      0x0016  timer1 compare b
   // 12     14      0x0018  timer1 overflow
   // 13     15      0x001A  timer0 compare a
   // 14     16      0x001C  timer0 compare b
   // 15     17      0x001E  timer0 overflow
   // 16     18      0x0020  serial transfer complete
   // 17     19      0x0022  serial receive complete
   // 18     20      0x0024  serial tx data empty
   // 19     21      0x0026  serial transmit complete
   // 20     22      0x0028  converter complete
   // 21     23      0x002A  eeprom ready
   // 22     24      0x002C  analog comparator
   // 23     25      0x002E  two-wire serial
   // 24     26      0x0030  store program ready

   // ****************************************
   // change sequence timing
   // ****************************************
   // edge c0: write with the change enable bit set opens the window
   // edges c1..c3: change enable stands, interrupts are held off
   // edge c4: window closes by itself if no select write came
   // a select write inside the window updates the select bit at once
   // the table start follows one edge after the select bit
   // after a select write the hold lasts until the next retired instruction
   // the global interrupt flag is never touched by the hold
   // a new enable write restarts the window and takes over the hold
   // when a release and a new enable write meet, the hold stays on
   // a select write outside the window is dropped without trace
   // requests raised during the hold are kept pending by their sources
   // and are presented once the hold is gone, lowest index first
   // the reset address follows the fuse on every edge out of reset; reset itself loads 0x0000 whatever the fuse

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic                 vector_select;
      logic                 change_enable;
      logic [2:0]           change_count;
      logic                 block;
      logic                 wait_instr;
      logic [ADDR_W-1:0]    reset_addr;
      logic [ADDR_W-1:0]    table_start;
      logic                 irq_request;
      logic [ADDR_W-1:0]    irq_addr;
      logic [IRQ_IDX_W-1:0] irq_index;
   } state_t;

   localparam state_t STATE_RESET = '{
      vector_select: VECTOR_SELECT_RESET,
      change_enable: 1'b0,
      change_count:  3'h0,
      block:         1'b0,
      wait_instr:    1'b0,
      reset_addr:    RESET_ADDR,
      table_start:   TABLE_BASE_APP,
      irq_request:   1'b0,
      irq_addr:      TABLE_BASE_APP,
      irq_index:     5'h00
   };

   state_t state;
   state_t next_state;

   logic                 found;
   logic [IRQ_IDX_W-1:0] win_index;
   logic                 wr_ce;
   logic                 wr_sel;

   // ****************************************
   // next state
   // ****************************************
   // lower index wins because the loop scans downward and the last hit stays
   always_comb begin
      next_state = state;
      found      = 1'b0;
      win_index  = 5'h00;
      wr_ce      = i_ctrl_write && i_ctrl_wdata[VECTOR_CHANGE_ENABLE_BIT];
      // a select write only counts inside the open change window
      wr_sel     = i_ctrl_write && !i_ctrl_wdata[VECTOR_CHANGE_ENABLE_BIT] && state.change_enable;

      // reset address from the fuse alone
      next_state.reset_addr = (i_boot_reset_fuse == FUSE_UNPROGRAMMED) ? RESET_ADDR
                                                                       : BOOT_RESET_ADDR;
      // table start from the select bit alone
      next_state.table_start = state.vector_select ? BOOT_RESET_ADDR + VECTOR_STRIDE
                                                   : TABLE_BASE_APP;

      // change enable window
      if (wr_sel) begin
         next_state.vector_select = i_ctrl_wdata[VECTOR_SELECT_BIT];
         next_state.change_enable = 1'b0;
         next_state.change_count  = 3'h0;
         next_state.wait_instr    = 1'b1;
      end else if (wr_ce) begin
         next_state.change_enable = 1'b1;
         next_state.change_count  = CHANGE_WINDOW_COUNT - 3'h1;
         next_state.block         = 1'b1;
         // the restarted window owns the hold from here on
         next_state.wait_instr    = 1'b0;
      end else if (state.change_enable) begin
         if (state.change_count == 3'h0) begin
            next_state.change_enable = 1'b0;
            next_state.block         = 1'b0;
         end else begin
            next_state.change_count = state.change_count - 3'h1;
         end
      end

      // hold the block through the instruction after the select write
      // an enable write in the same cycle wins over the release
      if (state.wait_instr && i_instr_done && !wr_ce) begin
         next_state.wait_instr = 1'b0;
         next_state.block      = 1'b0;
      end

      // priority pick over pending sources
      for (int k = NUM_IRQ - 1; k >= 0; k--) begin
         if (i_irq_pending[k]) begin
            found     = 1'b1;
            win_index = 5'(k);
         end
      end

      // vector address is slot offset on top of table start; no slot is held back
      if (state.irq_request && i_irq_ack) begin
         next_state.irq_request = 1'b0;
      end else begin
         next_state.irq_request = found && i_global_enable && !state.block && !wr_ce;
         next_state.irq_index   = win_index;
         next_state.irq_addr    = state.table_start + ADDR_W'({win_index, 1'b0});
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= STATE_RESET;
      end else begin
         state <= next_state;
      end
   end

   // outputs straight from flip-flops
   assign o_reset_addr           = state.reset_addr;
   assign o_table_start          = state.table_start;
   assign o_irq_request          = state.irq_request;
   assign o_irq_vector_addr      = state.irq_addr;
   assign o_irq_index            = state.irq_index;
   assign o_vector_select        = state.vector_select;
   assign o_vector_change_enable = state.change_enable;
   assign o_irq_blocked          = state.block;

endmodule

// ===== verif/vector_place_properties.sv
// port checker for vector placement
`timescale 1ns/1ns
module vector_place_checker
   import vector_place_pkg::*;
#(
   parameter logic [13:0] BOOT_RESET_ADDR = BOOT_RESET_DEFAULT
) (
   input wire logic        i_clock,
   input wire logic        i_nrst,
   input wire logic        i_boot_reset_fuse,
   input wire logic        i_ctrl_write,
   input wire logic [7:0]  i_ctrl_wdata,
   input wire logic [24:0] i_irq_pending,
   input wire logic [13:0] o_reset_addr,
   input wire logic [13:0] o_table_start,
   input wire logic        o_irq_request,
   input wire logic [13:0] o_irq_vector_addr,
   input wire logic [4:0]  o_irq_index,
   input wire logic        o_vector_select,
   input wire logic        o_vector_change_enable,
   input wire logic        o_irq_blocked
);
   // write decode and lower-index (higher-priority) mask
   wire        en_wr  = i_ctrl_write & i_ctrl_wdata[0];
   wire        sel_wr = i_ctrl_write & ~i_ctrl_wdata[0];
   wire [24:0] below  = (25'h1 << o_irq_index) - 25'h1;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   a_reset_addr_fuse: assert property ($past(i_nrst) |->
      o_reset_addr == ($past(i_boot_reset_fuse) ? 14'h0000 : BOOT_RESET_ADDR)) else $error("bad reset addr");
   a_table_start_sel: assert property ($past(i_nrst) |->
      o_table_start == ($past(o_vector_select) ? BOOT_RESET_ADDR + 14'h0002 : 14'h0002)) else $error("bad base");
   a_vector_addr_calc: assert property (o_irq_request |->
      o_irq_vector_addr == o_table_start + {o_irq_index, 1'b0}) else $error("bad vector");
   a_enable_blocks_irq: assert property (en_wr |=>
      o_vector_change_enable && o_irq_blocked && !o_irq_request) else $error("no block");
   a_window_closes: assert property (en_wr ##1 !i_ctrl_write [*4] |=>
      !o_vector_change_enable && !o_irq_blocked) else $error("window open");
   a_select_write: assert property (sel_wr && o_vector_change_enable |=>
      o_vector_select == $past(i_ctrl_wdata[1]) && !o_vector_change_enable) else $error("select lost");
   a_select_guarded: assert property (i_ctrl_write && !o_vector_change_enable |=>
      $stable(o_vector_select)) else $error("unguarded select");
   a_lowest_first: assert property (o_irq_request |->
      ($past(i_irq_pending) & below) == 25'h0) else $error("wrong winner");
   c_reloc: cover property (o_irq_request && o_vector_select);
   c_expiry: cover property (o_vector_change_enable ##1 !o_vector_change_enable);
   c_boot: cover property (o_reset_addr == BOOT_RESET_ADDR);
endmodule
bind interrupt_vector_placement vector_place_checker #(.BOOT_RESET_ADDR(BOOT_RESET_ADDR)) u_chk (.*);

// ===== verif/core_fetch_model.sv
// core fetch side: acks vector requests, retires instructions
`timescale 1ns/1ns
module core_fetch_model (
   input  wire logic i_clock,
   input  wire logic i_nrst,
   input  wire logic i_irq_request,
   input  wire logic i_slow,
   output logic      o_irq_ack,
   output logic      o_instr_done
);
   logic [1:0] delay;
   // ack at once or after three waits; one instruction every other cycle
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_irq_ack    <= 1'b0;
         o_instr_done <= 1'b0;
         delay        <= 2'h0;
      end else begin
         o_instr_done <= ~o_instr_done;
         o_irq_ack    <= i_irq_request && !o_irq_ack && (!i_slow || delay == 2'h3);
         delay        <= (i_irq_request && !o_irq_ack) ? delay + 2'h1 : 2'h0;
      end
   end
endmodule

// ===== verif/interrupt_vector_placement_tb.sv
// bench for vector placement
`timescale 1ns/1ns
module interrupt_vector_placement_tb;
   import vector_place_pkg::*;
   localparam logic [13:0] BOOT = 14'h3C00;
   logic        i_clock, i_nrst, i_boot_reset_fuse, i_ctrl_write, i_instr_done, i_global_enable, i_irq_ack;
   logic        o_irq_request, o_vector_select, o_vector_change_enable, o_irq_blocked, slow;
   logic [7:0]  i_ctrl_wdata;
   logic [24:0] i_irq_pending;
   logic [13:0] o_reset_addr, o_table_start, o_irq_vector_addr;
   logic [4:0]  o_irq_index;
   int          n_errors, tests_run;
   interrupt_vector_placement #(.BOOT_RESET_ADDR(BOOT)) u_dut (.*);
   core_fetch_model u_core (.i_clock(i_clock), .i_nrst(i_nrst), .i_irq_request(o_irq_request),
      .i_slow(slow), .o_irq_ack(i_irq_ack), .o_instr_done(i_instr_done));
   task chk(input logic [13:0] got, input logic [13:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one control write, sampled at the second edge
   task wrc(input logic [7:0] d);
      @(posedge i_clock);
      i_ctrl_write <= 1'b1;
      i_ctrl_wdata <= d;
      @(posedge i_clock);
      i_ctrl_write <= 1'b0;
   endtask
   // raise pend, check the presented vector, hold until acked
   task serve(input logic [24:0] p, input logic [13:0] exp, input logic [4:0] idx);
      int k;
      @(posedge i_clock);
      i_irq_pending <= p;
      for (k = 0; k < 20 && o_irq_request !== 1'b1; k++) @(posedge i_clock);
      if (k == 20) begin
         n_errors++;
         give_verdict();
      end
      chk(o_irq_vector_addr, exp);
      chk(14'(o_irq_index), 14'(idx));
      for (k = 0; k < 20 && i_irq_ack !== 1'b1; k++) @(posedge i_clock);
      if (k == 20) begin
         n_errors++;
         give_verdict();
      end
      i_irq_pending <= 25'h0;
      repeat (2) @(posedge i_clock);
   endtask
   task scan(input logic [13:0] base);
      for (int k = 0; k < 25; k++) serve(25'h1 << k, base + 14'(2 * k), 5'(k));
   endtask
   // pending held off by the change window, then by a cleared global flag
   task held_off;
      wrc(8'h01);
      i_irq_pending <= 25'h1;
      repeat (3) @(posedge i_clock);
      chk(14'(o_irq_request), 14'h0000);
      serve(25'h1, 14'h0002, 5'h00);
      i_global_enable <= 1'b0;
      i_irq_pending <= 25'h2;
      repeat (3) @(posedge i_clock);
      chk(14'(o_irq_request), 14'h0000);
      i_global_enable <= 1'b1;
      serve(25'h2, 14'h0004, 5'h01);
   endtask
   task relocate(input logic v);
      wrc(8'h01);
      @(posedge i_clock);
      chk(14'({o_vector_change_enable, o_irq_blocked}), 14'h0003);
      wrc({6'h00, v, 1'b0});
      repeat (2) @(posedge i_clock);
      chk(o_table_start, v ? BOOT + 14'h0002 : 14'h0002);
      chk(o_reset_addr, 14'h0000);
   endtask
   task window_expiry;
      wrc(8'h01);
      repeat (6) @(posedge i_clock);
      chk(14'(o_vector_change_enable), 14'h0000);
      wrc(8'h02);
      repeat (2) @(posedge i_clock);
      chk(14'(o_vector_select), 14'h0000);
   endtask
   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end
   // reset, then scenarios
   initial begin
      {i_nrst, i_ctrl_write, slow, i_ctrl_wdata, i_irq_pending} = '0;
      {i_boot_reset_fuse, i_global_enable} = 2'h3;
      repeat (8) @(posedge i_clock);
      i_nrst <= 1'b1;
      i_boot_reset_fuse <= 1'b0;
      repeat (3) @(posedge i_clock);
      chk(o_reset_addr, BOOT);
      i_boot_reset_fuse <= 1'b1;
      repeat (3) @(posedge i_clock);
      chk(o_reset_addr, 14'h0000);
      scan(14'h0002);
      serve(25'h1000220, 14'h000C, 5'h05);
      window_expiry();
      held_off();
      relocate(1'b1);
      slow <= 1'b1;
      scan(BOOT + 14'h0002);
      relocate(1'b0);
      give_verdict();
   end
endmodule
